// [core/hmi_sys_pkg.sv]
// Purpose: Shared constants for the panel system control and status block
// Assumes: APB with 32-bit data, one word per register, byte address = 4 * index
// Notes: Indices above 0x2 are local additions for entry flags, interrupts and details
package hmi_sys_pkg;
    // Register indices
    localparam logic [5:0] IDX_CTRL = 6'h01;
    localparam logic [5:0] IDX_ERR = 6'h02;
    localparam logic [5:0] IDX_ENTRY = 6'h03;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h04;
    localparam logic [5:0] IDX_IRQ_EN = 6'h05;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h06;
    localparam logic [5:0] IDX_DET_LO = 6'h07;
    localparam logic [5:0] IDX_DET_HI = 6'h08;
    // Control word fields
    localparam int CTL_BACKLIGHT = 0;
    localparam int CTL_AUTO_OFF_DIS = 5;
    localparam int CTL_BEEP = 6;
    localparam int CTL_SCREEN = 7;
    localparam int CTL_CLR_ERR = 9;
    localparam int CTL_CLR_NUM = 10;
    localparam int CTL_CLR_TXT = 11;
    localparam logic [15:0] CTL_WMASK = 16'h0ee1;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // Error word fields
    localparam int ERR_COMM = 3;
    localparam int ERR_ARITH = 5;
    localparam int ERR_RANGE = 6;
    localparam int ERR_CLOCK = 7;
    localparam int ERR_SCRIPT = 10;
    localparam logic [15:0] ERR_MASK = 16'h04e8;
    localparam logic [15:0] ERR_RESET = 16'h0000;
    // Entry result word fields
    localparam int ENT_NUM_DONE = 0;
    localparam int ENT_NUM_CANCEL = 1;
    localparam int ENT_AUTO_OFF = 2;
    localparam int ENT_TXT_DONE = 5;
    localparam int ENT_TXT_CANCEL = 6;
    localparam logic [15:0] ENT_RESET = 16'h0000;
    // Idle switch-off time
    localparam longint IDLE_TIME_S = 600;
    localparam longint CLK_HZ = 25000000;
    localparam longint IDLE_CYCLES = IDLE_TIME_S * CLK_HZ;
endpackage

// [core/idle_timer.sv]
// Purpose: Counts clock cycles of panel inactivity and flags expiry
// Assumes: Restart and enable come from logic on the same clock
// Notes: Counter halts at LIMIT - 1 until restarted or disabled
`timescale 1ns/1ps
module idle_timer #(
    parameter longint LIMIT = hmi_sys_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic restart,
    // Status
    output logic expired
);
    logic [63:0] cnt_q;
    logic [63:0] cnt_d;
    logic hit;

    // Terminal count compare
    assign hit = (cnt_q == 64'(LIMIT - 1));
    assign cnt_d = (!enable || restart) ? 64'h0 : (hit ? cnt_q : cnt_q + 64'h1);

    // Counter and one-cycle expiry pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 64'h0;
            expired <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            expired <= enable && !restart && (cnt_q == 64'(LIMIT - 2));
        end
    end
endmodule

// [core/hmi_sys_ctrl.sv]
// Purpose: System control word and error status word of an operator panel, on APB
// Assumes: Event inputs are one-cycle pulses on CLK_SYS; TOUCH_ACT is an async pin
// Notes: One wait state on every APB access; unmapped indices answer with PSLVERR
// Notes on behaviour
// - Auto-off setting zero: backlight goes dark after long panel idleness.
// - Setting one stops idle switch-off; changing to one relights dark backlight.
// - Beep bit reads back, resets zero; one beeps continuously, zero stops.
// - Screen display bit stores state like backlight bit; writes change it.
// - Clear-error command zeroes whole error word, then drops to zero itself.
// - Numeric clear command zeroes numeric done and cancel flags, self-clears.
// - Text clear command zeroes text done and cancel flags, self-clears.
// - Whole error and status word is zero after power-up.
// - Serial port one data exchange failure sets communication error flag.
// - Bad packed digit, divide by zero or bad chart limits set arithmetic flag.
// - Out-of-range device write or too many devices sets range flag.
// - Stopped real-time clock sets clock error flag.
// - Script failure sets script flag and stores two detail words.
// - Backlight bit zero means off, one means on.
// - Auto-off setting sits in control bit 5, zero after power-up.
`timescale 1ns/1ps
module hmi_sys_ctrl #(
    parameter longint IDLE_CYCLES = hmi_sys_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Error events
    input wire logic FIRST_SERIAL_PORT_ERR,
    input wire logic ARITH_ERR,
    input wire logic RANGE_ERR,
    input wire logic CLOCK_STOPPED,
    input wire logic SCRIPT_ERR,
    input wire logic [15:0] SCRIPT_ERROR_DETAIL_LO,
    input wire logic [15:0] SCRIPT_ERROR_DETAIL_HI,
    // Entry result events
    input wire logic NUM_DONE,
    input wire logic NUM_CANCEL,
    input wire logic TXT_DONE,
    input wire logic TXT_CANCEL,
    // Panel activity pin
    input wire logic TOUCH_ACT,
    // Panel outputs
    output logic BACKLIGHT_ON,
    output logic SCREEN_ON,
    output logic BEEP_ON,
    output logic IRQ
);
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] err_q, err_d;
    logic [15:0] ent_q, ent_d;
    logic [15:0] istat_q, istat_d;
    logic [15:0] ien_q;
    logic [15:0] det_lo_q, det_hi_q;
    logic backlight_q, backlight_d;
    logic auto_dark_q, auto_dark_d;
    logic [2:0] touch_sync_q;
    logic touch_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic irq_q;

    // Bus decode
    logic access, wr_en, hit_ok;
    logic [5:0] idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr_ctrl, wr_ien, wr_iclr;
    logic [15:0] err_evt, ent_evt;
    logic touch_evt, idle_expired, auto_on;

    assign access = PSEL && PENABLE && !pready_q;
    assign wr_en = PSEL && PENABLE && pready_q && PWRITE && hit_ok;
    assign idx = PADDR[7:2];
    assign wdata = PWDATA[15:0];
    assign hit_ok = (PADDR[1:0] == 2'h0) && (idx >= hmi_sys_pkg::IDX_CTRL)
                    && (idx <= hmi_sys_pkg::IDX_DET_HI);
    assign wr_ctrl = wr_en && (idx == hmi_sys_pkg::IDX_CTRL);
    assign wr_ien = wr_en && (idx == hmi_sys_pkg::IDX_IRQ_EN);
    assign wr_iclr = wr_en && (idx == hmi_sys_pkg::IDX_IRQ_CLR);

    // Read multiplexer; reserved bits read zero
    assign rdata = (idx == hmi_sys_pkg::IDX_CTRL) ?
                       ((ctrl_q & ~16'h0001) | {15'h0, backlight_q}) :
                   (idx == hmi_sys_pkg::IDX_ERR) ? err_q :
                   (idx == hmi_sys_pkg::IDX_ENTRY) ? ent_q :
                   (idx == hmi_sys_pkg::IDX_IRQ_STAT) ? istat_q :
                   (idx == hmi_sys_pkg::IDX_IRQ_EN) ? ien_q :
                   (idx == hmi_sys_pkg::IDX_DET_LO) ? det_lo_q :
                   (idx == hmi_sys_pkg::IDX_DET_HI) ? det_hi_q : 16'h0000;

    // Error event vector in error word layout
    assign err_evt = (16'(FIRST_SERIAL_PORT_ERR) << hmi_sys_pkg::ERR_COMM)
                   | (16'(ARITH_ERR) << hmi_sys_pkg::ERR_ARITH)
                   | (16'(RANGE_ERR) << hmi_sys_pkg::ERR_RANGE)
                   | (16'(CLOCK_STOPPED) << hmi_sys_pkg::ERR_CLOCK)
                   | (16'(SCRIPT_ERR) << hmi_sys_pkg::ERR_SCRIPT);
    assign ent_evt = (16'(NUM_DONE) << hmi_sys_pkg::ENT_NUM_DONE)
                   | (16'(NUM_CANCEL) << hmi_sys_pkg::ENT_NUM_CANCEL)
                   | (16'(TXT_DONE) << hmi_sys_pkg::ENT_TXT_DONE)
                   | (16'(TXT_CANCEL) << hmi_sys_pkg::ENT_TXT_CANCEL);

    // Sticky error word: events win over the clear command
    assign err_d = (ctrl_q[hmi_sys_pkg::CTL_CLR_ERR] ? 16'h0000 : err_q)
                   | err_evt;

    // Entry flags: clear commands act on their pairs, events win
    always_comb begin
        ent_d = ent_q;
        if (ctrl_q[hmi_sys_pkg::CTL_CLR_NUM]) begin
            ent_d[hmi_sys_pkg::ENT_NUM_DONE] = 1'b0;
            ent_d[hmi_sys_pkg::ENT_NUM_CANCEL] = 1'b0;
        end
        if (ctrl_q[hmi_sys_pkg::CTL_CLR_TXT]) begin
            ent_d[hmi_sys_pkg::ENT_TXT_DONE] = 1'b0;
            ent_d[hmi_sys_pkg::ENT_TXT_CANCEL] = 1'b0;
        end
        ent_d = ent_d | ent_evt;
        ent_d[hmi_sys_pkg::ENT_AUTO_OFF] = auto_dark_d;
    end

    // Control word: commands last one cycle after being written
    always_comb begin
        ctrl_d = ctrl_q;
        ctrl_d[hmi_sys_pkg::CTL_CLR_ERR] = 1'b0;
        ctrl_d[hmi_sys_pkg::CTL_CLR_NUM] = 1'b0;
        ctrl_d[hmi_sys_pkg::CTL_CLR_TXT] = 1'b0;
        if (wr_ctrl) begin
            ctrl_d = wdata & hmi_sys_pkg::CTL_WMASK;
        end
    end

    // Auto-off setting going to one relights a dark backlight
    assign auto_on = wr_ctrl && wdata[hmi_sys_pkg::CTL_AUTO_OFF_DIS]
                     && !ctrl_q[hmi_sys_pkg::CTL_AUTO_OFF_DIS];

    // Backlight state
    always_comb begin
        backlight_d = backlight_q;
        auto_dark_d = auto_dark_q;
        if (idle_expired && !ctrl_q[hmi_sys_pkg::CTL_AUTO_OFF_DIS]) begin
            backlight_d = 1'b0;
            auto_dark_d = 1'b1;
        end
        if (touch_evt && auto_dark_q) begin
            backlight_d = 1'b1;
        end
        if (wr_ctrl) begin
            backlight_d = wdata[hmi_sys_pkg::CTL_BACKLIGHT];
        end
        if (auto_on && !backlight_q) begin
            backlight_d = 1'b1;
        end
        if (backlight_d) begin
            auto_dark_d = 1'b0;
        end
    end

    // Interrupt status: sticky, write-one-to-clear, set wins
    assign istat_d = ((wr_iclr ? (istat_q & ~wdata) : istat_q) | err_evt)
                     & hmi_sys_pkg::ERR_MASK;

    // Activity edge after the synchroniser agrees
    assign touch_evt = (touch_sync_q[1] == touch_sync_q[2]) && touch_sync_q[2] && !touch_q;

    // Idle counter, runs only while lit with idle switch-off allowed
    idle_timer #(
        .LIMIT(IDLE_CYCLES)
    ) u_idle (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .enable(backlight_q && !ctrl_q[hmi_sys_pkg::CTL_AUTO_OFF_DIS]),
        .restart(touch_evt || wr_ctrl),
        .expired(idle_expired)
    );

    // Register state
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ctrl_q <= hmi_sys_pkg::CTL_RESET;
            err_q <= hmi_sys_pkg::ERR_RESET;
            ent_q <= hmi_sys_pkg::ENT_RESET;
            istat_q <= 16'h0000;
            ien_q <= 16'h0000;
            backlight_q <= 1'b1;
            auto_dark_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            err_q <= err_d;
            ent_q <= ent_d;
            istat_q <= istat_d;
            ien_q <= wr_ien ? (wdata & hmi_sys_pkg::ERR_MASK) : ien_q;
            backlight_q <= backlight_d;
            auto_dark_q <= auto_dark_d;
        end
    end

    // Script detail capture
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            det_lo_q <= 16'h0000;
            det_hi_q <= 16'h0000;
        end else if (SCRIPT_ERR) begin
            det_lo_q <= SCRIPT_ERROR_DETAIL_LO;
            det_hi_q <= SCRIPT_ERROR_DETAIL_HI;
        end
    end

    // Activity pin synchroniser
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            touch_sync_q <= 3'h0;
            touch_q <= 1'b0;
        end else begin
            touch_sync_q <= {touch_sync_q[1:0], TOUCH_ACT};
            touch_q <= (touch_sync_q[1] == touch_sync_q[2]) ? touch_sync_q[2] : touch_q;
        end
    end

    // APB answer with one wait state
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access;
            prdata_q <= (access && !PWRITE && hit_ok) ? {16'h0, rdata} : 32'h0;
            pslverr_q <= access && !hit_ok;
        end
    end

    // Interrupt output register
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(istat_d & ien_q);
        end
    end

    // Outputs straight from their registers
    assign PREADY = pready_q;
    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q;
    assign BACKLIGHT_ON = backlight_q;
    assign SCREEN_ON = ctrl_q[hmi_sys_pkg::CTL_SCREEN];
    assign BEEP_ON = ctrl_q[hmi_sys_pkg::CTL_BEEP];
    assign IRQ = irq_q;

    // Checks
    clear_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ctrl_q[hmi_sys_pkg::CTL_CLR_ERR] && err_evt == 16'h0 |=> err_q == 16'h0)
        else $error("error word not cleared by command");
    cmd_selfclr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ctrl_q[hmi_sys_pkg::CTL_CLR_ERR] && !wr_ctrl |=> !ctrl_q[hmi_sys_pkg::CTL_CLR_ERR])
        else $error("clear-error command did not self-clear");
    num_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ctrl_q[hmi_sys_pkg::CTL_CLR_NUM] && !NUM_DONE && !NUM_CANCEL
        |=> !ent_q[hmi_sys_pkg::ENT_NUM_DONE] && !ent_q[hmi_sys_pkg::ENT_NUM_CANCEL])
        else $error("numeric entry flags not cleared");
    txt_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ctrl_q[hmi_sys_pkg::CTL_CLR_TXT] && !TXT_DONE && !TXT_CANCEL
        |=> !ent_q[hmi_sys_pkg::ENT_TXT_DONE] && !ent_q[hmi_sys_pkg::ENT_TXT_CANCEL])
        else $error("text entry flags not cleared");
    beep_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_ctrl |=> BEEP_ON == $past(PWDATA[hmi_sys_pkg::CTL_BEEP]))
        else $error("beep output does not follow written value");
    err_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ##1 (err_q & ~$past(err_q) & ~$past(err_evt)) == 16'h0)
        else $error("error flag rose without an event");
    err_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !ctrl_q[hmi_sys_pkg::CTL_CLR_ERR] |=> (err_q & $past(err_q)) == $past(err_q))
        else $error("error flag dropped without clear");
    comm_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        FIRST_SERIAL_PORT_ERR |=> err_q[hmi_sys_pkg::ERR_COMM])
        else $error("communication error flag not set");
    relight_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        auto_on && !backlight_q |=> BACKLIGHT_ON)
        else $error("backlight not relit by auto-off disable");
    apb_ready_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not a single-cycle answer");
    screen_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_ctrl |=> SCREEN_ON == $past(PWDATA[hmi_sys_pkg::CTL_SCREEN]))
        else $error("screen output does not follow written value");
    light_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        wr_ctrl && !auto_on |=> BACKLIGHT_ON == $past(PWDATA[hmi_sys_pkg::CTL_BACKLIGHT]))
        else $error("backlight does not follow written value");
    idle_dark_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        idle_expired && !ctrl_q[hmi_sys_pkg::CTL_AUTO_OFF_DIS] && !wr_ctrl && !touch_evt
        |=> !BACKLIGHT_ON)
        else $error("backlight not dark after idle time");
    reset_zero_a: assert property (@(posedge CLK_SYS)
        !RST_N |=> err_q == hmi_sys_pkg::ERR_RESET && !ctrl_q[hmi_sys_pkg::CTL_AUTO_OFF_DIS])
        else $error("error word or auto-off setting not zero after reset");
endmodule

// [bench/tb.sv]
// Purpose: Self-checking bench for the panel system control and status block
// Assumes: APB master driven on rising edges; idle limit shortened to IDLE cycles
// Notes: Event pulses come from one vector, ordinary cases from the rows table
`timescale 1ns/1ps
module tb;
    localparam longint IDLE = 20;
    typedef struct {logic [8:0] ev; logic [15:0] err; logic [15:0] ent;} row_t;
    // Ordinary cases: event pulse, expected error word, expected entry word
    row_t rows[9] = '{'{9'h001, 16'h0008, 16'h0000}, '{9'h002, 16'h0020, 16'h0000},
        '{9'h004, 16'h0040, 16'h0000}, '{9'h008, 16'h0080, 16'h0000},
        '{9'h010, 16'h0400, 16'h0000}, '{9'h020, 16'h0000, 16'h0001},
        '{9'h040, 16'h0000, 16'h0002}, '{9'h080, 16'h0000, 16'h0020},
        '{9'h100, 16'h0000, 16'h0040}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [8:0] ev = 9'h000;
    logic touch = 1'b0;
    logic [15:0] det_lo = 16'h1234;
    logic [15:0] det_hi = 16'habcd;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, bl, scr, beep, irq;
    int n;
    int miscompares = 0;
    int compares = 0;

    // Clock of 40 ns period
    always #20 clk = ~clk;

    hmi_sys_ctrl #(.IDLE_CYCLES(IDLE)) uut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .FIRST_SERIAL_PORT_ERR(ev[0]), .ARITH_ERR(ev[1]),
        .RANGE_ERR(ev[2]), .CLOCK_STOPPED(ev[3]), .SCRIPT_ERR(ev[4]),
        .SCRIPT_ERROR_DETAIL_LO(det_lo), .SCRIPT_ERROR_DETAIL_HI(det_hi), .NUM_DONE(ev[5]),
        .NUM_CANCEL(ev[6]), .TXT_DONE(ev[7]), .TXT_CANCEL(ev[8]), .TOUCH_ACT(touch),
        .BACKLIGHT_ON(bl), .SCREEN_ON(scr), .BEEP_ON(beep), .IRQ(irq));

    // Verdict and end of run
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error taken in the ready cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready is sampled at the rising edge; answer taken and request released there
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // One-cycle event pulse
    task automatic pulse(input logic [8:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 9'h000;
    endtask

    // Bounded wait for a backlight level; n counts the cycles taken
    task automatic wait_bl(input logic v);
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (bl === v) break;
        end
        if (n == 200) begin
            miscompares++;
            end_sim();
        end
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({bl, scr, beep, irq, pready, pslverr}, 6'h20);
        rdchk(8'h04, 32'h1);
        rdchk(8'h08, 32'h0);
        wr(8'h04, 32'h21);
        for (int k = 0; k < 9; k++) begin
            pulse(rows[k].ev);
            rdchk(8'h08, {16'h0, rows[k].err});
            rdchk(8'h0c, {16'h0, rows[k].ent});
            wr(8'h04, 32'h0e21);
            rdchk(8'h04, 32'h21);
            rdchk(8'h08, 32'h0);
            rdchk(8'h0c, 32'h0);
        end
        // Numeric clear touches only its own flags; text and error clears then empty the rest
        pulse(9'h0a1);
        wr(8'h04, 32'h0421);
        rdchk(8'h0c, 32'h20);
        rdchk(8'h08, 32'h8);
        wr(8'h04, 32'h0821);
        rdchk(8'h0c, 32'h0);
        wr(8'h04, 32'h0221);
        rdchk(8'h08, 32'h0);
        // Detail inputs move later; the captured words must not follow them
        @(posedge clk);
        det_lo <= 16'h0f0f;
        det_hi <= 16'hf0f0;
        rdchk(8'h1c, 32'h1234);
        rdchk(8'h20, 32'habcd);
        // Auto-off disabled: stays lit past the idle limit
        repeat (3 * IDLE) @(posedge clk);
        chk(bl, 32'h1);
        // Beep and screen follow their bits
        wr(8'h04, 32'he1);
        @(negedge clk);
        chk({scr, beep, bl}, 3'h7);
        rdchk(8'h04, 32'he1);
        wr(8'h04, 32'h20);
        @(negedge clk);
        chk({scr, beep, bl}, 3'h0);
        // Auto-off enabled: goes dark after the idle limit
        wr(8'h04, 32'h01);
        wait_bl(1'b0);
        chk(32'(n > IDLE - 5 && n < IDLE + 5), 32'h1);
        rdchk(8'h0c, 32'h4);
        // Touch relights, then idle again and relight by setting auto-off disable
        @(posedge clk);
        touch <= 1'b1;
        repeat (2) @(posedge clk);
        touch <= 1'b0;
        wait_bl(1'b1);
        rdchk(8'h0c, 32'h0);
        wait_bl(1'b0);
        wr(8'h04, 32'h20);
        repeat (2) @(negedge clk);
        chk(bl, 32'h1);
        // Interrupt: clear, enable one source, mask another
        wr(8'h18, 32'h04e8);
        rdchk(8'h10, 32'h0);
        wr(8'h14, 32'h8);
        rdchk(8'h14, 32'h8);
        pulse(9'h002);
        repeat (3) @(negedge clk);
        chk(irq, 1'b0);
        pulse(9'h001);
        repeat (3) @(negedge clk);
        chk(irq, 1'b1);
        rdchk(8'h10, 32'h28);
        wr(8'h18, 32'h8);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        rdchk(8'h10, 32'h20);
        // Read-only, reserved, unmapped and misaligned accesses
        wr(8'h08, 32'hffff);
        chk(er, 1'b0);
        rdchk(8'h08, 32'h28);
        wr(8'h04, 32'hf121);
        rdchk(8'h04, 32'h21);
        rdchk(8'h24, 32'h0);
        chk(er, 1'b1);
        rdchk(8'h05, 32'h0);
        chk(er, 1'b1);
        // Reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({bl, scr, beep, irq}, 4'h8);
        rdchk(8'h08, 32'h0);
        rdchk(8'h04, 32'h1);
        end_sim();
    end
endmodule
